//--- src/bcch_consts.svh
// Constants for the board-control command handler
// How it works
// - Adapter byte FFh marks board-control command
// - Code 02h halts command-list operation
// - Halt drains queue, then returns status
// - Halt when already stopped gives error 11h
// - Code 05h returns identity status block
// - Identity accepted from single or list
// - Identifier copied into status word zero
// - Flags bit7 complete, bit6 error, rest zero
// - Error byte carries code with error flag
// - Option bit 4 reports bus-reset jumper
// - SCSI ID spread over option bits 0,7,6,5
// - Build date and even-store firmware number
// - Engineering revision separate from release level
// - Code 06h is the statistics request
// - Clear off writes statistics to memory
// - Clear set zeroes table, no transfer
// - Statistics counters volatile, reset clears them
// - Statistics writes use block address modifier
`ifndef BCCH_CONSTS_SVH
`define BCCH_CONSTS_SVH
`define BCCH_ADAPTER_BOARD   8'hff
`define BCCH_CMD_STOP        8'h02
`define BCCH_CMD_IDENT       8'h05
`define BCCH_CMD_STATS       8'h06
`define BCCH_ERR_NOT_RUNNING 8'h11
`define BCCH_ERR_BAD_CMD     8'h01
`define BCCH_FLAG_DONE_BIT   7
`define BCCH_FLAG_ERR_BIT    6
`define BCCH_OPT_CLR_BIT     0
`define BCCH_OPT_FIXED       3'b010
`define BCCH_STAT_WORDS      5'd19
`define BCCH_STAT_LAST       5'd18
// Register byte offsets on the bus
`define BCCH_REG_W0     12'h000
`define BCCH_REG_W1     12'h004
`define BCCH_REG_W2     12'h008
`define BCCH_REG_W3     12'h00c
`define BCCH_REG_W4     12'h010
`define BCCH_REG_GO     12'h014
`define BCCH_REG_CTRL   12'h018
`define BCCH_REG_STAT   12'h01c
`define BCCH_REG_SB0    12'h020
`define BCCH_REG_SB1    12'h024
`define BCCH_REG_SB2    12'h028
`define BCCH_REG_SB3    12'h02c
`define BCCH_REG_EVT    12'h030
`endif

//--- src/bcch_pkg.sv
// Types shared by the board-control command handler
package bcch_pkg;
	// Handler states, Gray in declaration order only
	typedef enum logic [2:0] {
		BCCH_IDLE  = 3'b000,
		BCCH_DEC   = 3'b001,
		BCCH_DRAIN = 3'b011,
		BCCH_XFER  = 3'b010,
		BCCH_DONE  = 3'b110
	} bcch_state_e;
	// Outbound memory write
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [5:0]  amod;
		logic [31:0] data;
	} bcch_mwr_s;
	// Fixed identity data
	typedef struct packed {
		logic [7:0]  fw_rel;
		logic [7:0]  eng_rev;
		logic [7:0]  day;
		logic [7:0]  month;
		logic [7:0]  year;
		logic [15:0] fw_num;
	} bcch_ident_s;
endpackage

//--- src/bcch_top.sv
// Board-control command handler with an AHB-Lite register slave
`include "bcch_consts.svh"
module bcch_top #(
	parameter logic [7:0]  FW_REL  = 8'h01, // Arbitrary value
	parameter logic [7:0]  ENG_REV = 8'h01, // Arbitrary value
	parameter logic [7:0]  DAY     = 8'h01,
	parameter logic [7:0]  MONTH   = 8'h01,
	parameter logic [7:0]  YEAR    = 8'h00,
	parameter logic [15:0] FW_NUM  = 16'h0001 // Arbitrary value
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	// AHB-Lite slave
	input  wire logic              hsel_in,
	input  wire logic [31:0]       haddr_in,
	input  wire logic [1:0]        htrans_in,
	input  wire logic              hwrite_in,
	input  wire logic [2:0]        hsize_in,
	input  wire logic [31:0]       hwdata_in,
	input  wire logic              hready_in,
	output logic [31:0]            hrdata_out,
	output logic                   hreadyout_out,
	output logic                   hresp_out,
	// Jumpers and queue status
	input  wire logic [3:0]        scsi_id_in,
	input  wire logic              bus_reset_jumper_in,
	input  wire logic              queue_empty_in,
	// Statistics events
	input  wire logic              cmd_done_evt_in,
	input  wire logic              check_cond_evt_in,
	input  wire logic              tgt_sel_evt_in,
	input  wire logic              scsi_cmd_evt_in,
	input  wire logic [3:0]        scsi_cmd_id_in,
	// Memory write port
	output bcch_pkg::bcch_mwr_s    mwr_out,
	input  wire logic              mwr_ready_in,
	// Command-list control
	output logic                   list_running_out,
	output logic                   list_accept_out
);
	// Parameter block words and status block
	logic [31:0] pb [5];                  // Parameter block, words 0 to 4
	logic [31:0] sb [4];                  // Status block, words 0 to 3
	// Sequencer state
	logic        list_on;                 // Command list running
	logic        halting;                 // Halt seen, queue draining
	logic        busy;                    // A command is in progress
	logic        done_p;                  // Last cycle of a command
	logic [31:0] stat [`BCCH_STAT_WORDS]; // Statistics table
	bcch_pkg::bcch_state_e state;         // Sequencer state
	bcch_pkg::bcch_state_e next_state;    // Its next value
	logic [4:0]  widx;                    // Statistics word index
	logic [4:0]  next_widx;               // Its next value
	logic [7:0]  err;                     // Error code of this command
	logic [7:0]  next_err;                // Its next value
	logic        next_list_on;            // Next list running
	logic        next_halting;            // Next halt flag
	// Bus pipeline registers
	logic        dp_wr;                   // Write data phase pending
	logic [11:0] dp_addr;                 // Address of that data phase
	logic        go_wr;                   // Go written while idle
	logic        clr_done;                // Clear request decoded
	// Decoded fields
	logic [7:0]  adapter_byte, cmd_code, amod;
	logic        clr_opt;
	assign adapter_byte = pb[1][7:0];
	assign amod         = pb[1][15:8];
	assign cmd_code     = pb[4][31:24];
	assign clr_opt      = pb[4][16+`BCCH_OPT_CLR_BIT];
	// Option flags byte: ID bits 2 to 0 on top, jumper, fixed
	// pattern, then ID bit 3 in the lowest bit
	logic [7:0] opt_flags;                // Identity option flags
	assign opt_flags = {scsi_id_in[2:0],
		bus_reset_jumper_in,
		`BCCH_OPT_FIXED, scsi_id_in[3]};
	// Address phase capture; only writes need a data phase, reads
	// are answered from the address edge
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dp_wr   <= 1'b0;
			dp_addr <= 12'h000;
		end else if (hready_in) begin
			// Write pending for the coming data phase
			dp_wr   <= hsel_in & htrans_in[1] & hwrite_in;
			dp_addr <= haddr_in[11:0];
		end
	end
	// Zero wait states, always OKAY
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	// Go strobe, one entry for either command structure
	assign go_wr   = dp_wr && dp_addr == `BCCH_REG_GO && !busy;
	// Busy whenever the sequencer has left idle
	assign busy    = state != bcch_pkg::BCCH_IDLE;
	// Parameter block writes, ignored while busy
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < 5; i++) pb[i] <= 32'h0;
		end else if (dp_wr && !busy) begin
			// Word select by byte offset
			if (dp_addr == `BCCH_REG_W0) pb[0] <= hwdata_in;
			else if (dp_addr == `BCCH_REG_W1) pb[1] <= hwdata_in;
			else if (dp_addr == `BCCH_REG_W2) pb[2] <= hwdata_in;
			else if (dp_addr == `BCCH_REG_W3) pb[3] <= hwdata_in;
			else if (dp_addr == `BCCH_REG_W4) pb[4] <= hwdata_in;
		end
	end
	// Read mux, registered data
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) hrdata_out <= 32'h0;
		else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
			if (haddr_in[11:0] == `BCCH_REG_SB0) hrdata_out <= sb[0];
			else if (haddr_in[11:0] == `BCCH_REG_SB1) hrdata_out <= sb[1];
			else if (haddr_in[11:0] == `BCCH_REG_SB2) hrdata_out <= sb[2];
			else if (haddr_in[11:0] == `BCCH_REG_SB3) hrdata_out <= sb[3];
			// Status word: list on, halting, busy
			else if (haddr_in[11:0] == `BCCH_REG_STAT)
				hrdata_out <= {29'h0, list_on, halting, busy};
			else if (haddr_in[11:0] == `BCCH_REG_W0) hrdata_out <= pb[0];
			else hrdata_out <= 32'h0;
		end
	end
	// Start command list via CTRL bit0 (list run enable)
	logic start_wr;
	assign start_wr = dp_wr && dp_addr == `BCCH_REG_CTRL && hwdata_in[0];
	// Command sequencer next state
	always_comb begin
		next_state   = state;
		next_widx    = widx;
		next_err     = err;
		next_list_on = list_on | (start_wr & ~halting);
		next_halting = halting;
		case (state)
			// Wait for a go strobe
			bcch_pkg::BCCH_IDLE: begin
				if (go_wr) begin
					next_state = bcch_pkg::BCCH_DEC;
					next_err   = 8'h00;
				end
			end
			// Decode one parameter block; reserved fields unread
			bcch_pkg::BCCH_DEC: begin
				next_state = bcch_pkg::BCCH_DONE;
				next_widx  = 5'd0;
				if (adapter_byte != `BCCH_ADAPTER_BOARD) begin
					next_err = `BCCH_ERR_BAD_CMD;
				end else if (cmd_code == `BCCH_CMD_STOP) begin
					if (!list_on) next_err = `BCCH_ERR_NOT_RUNNING;
					else begin
						next_halting = 1'b1;
						next_state   = bcch_pkg::BCCH_DRAIN;
					end
				end else if (cmd_code == `BCCH_CMD_STATS) begin
					if (!clr_opt) next_state = bcch_pkg::BCCH_XFER;
				end else if (cmd_code != `BCCH_CMD_IDENT) begin
					next_err = `BCCH_ERR_BAD_CMD;
				end
			end
			// Hold the halt status until the queue runs dry
			bcch_pkg::BCCH_DRAIN: begin
				if (queue_empty_in) begin
					next_list_on = 1'b0;
					next_halting = 1'b0;
					next_state   = bcch_pkg::BCCH_DONE;
				end
			end
			// One statistics word per accepted memory write
			bcch_pkg::BCCH_XFER: begin
				if (mwr_ready_in) begin
					next_widx = widx + 5'd1;
					if (widx == `BCCH_STAT_LAST)
						next_state = bcch_pkg::BCCH_DONE;
				end
			end
			// Status lands on leaving this state
			bcch_pkg::BCCH_DONE: next_state = bcch_pkg::BCCH_IDLE;
			// Unused codes fall back to idle
			default: next_state = bcch_pkg::BCCH_IDLE;
		endcase
	end
	// Sequencer registers
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state   <= bcch_pkg::BCCH_IDLE;
			widx    <= 5'd0;
			err     <= 8'h00;
			list_on <= 1'b0;
			halting <= 1'b0;
		end else begin
			state   <= next_state;
			widx    <= next_widx;
			err     <= next_err;
			list_on <= next_list_on;
			halting <= next_halting;
		end
	end
	assign done_p = state == bcch_pkg::BCCH_DONE;
	assign list_running_out = list_on;
	assign list_accept_out  = list_on & ~halting;
	// Status block; flags byte lands last, on the DONE edge
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < 4; i++) sb[i] <= 32'h0;
		end else if (go_wr) begin
			sb[1] <= 32'h0; // Clear flags for polling
		end else if (state == bcch_pkg::BCCH_DEC) begin
			// Body words first, while the flags still read zero
			sb[0] <= pb[0];
			sb[2] <= {DAY, MONTH, YEAR, opt_flags};
			sb[3] <= {FW_NUM, 16'h0000};
		end else if (done_p) begin
			// Error and flags together, last of all
			sb[1] <= {FW_REL, ENG_REV, err,
				(err == 8'h00) ? 8'h80 : 8'hc0};
		end
	end
	// Statistics table (volatile, cleared at reset)
	assign clr_done = state == bcch_pkg::BCCH_DEC && adapter_byte ==
		`BCCH_ADAPTER_BOARD && cmd_code == `BCCH_CMD_STATS && clr_opt;
	// One counter per table word; check conditions sit between
	// the counts for ID 7 and ID 8
	generate
		for (genvar g = 0; g < `BCCH_STAT_WORDS; g++) begin : g_stat
			logic hit; // Event for this word
			if (g == 0) assign hit = cmd_done_evt_in; // Commands done
			else if (g <= 8) assign hit = scsi_cmd_evt_in &&
				scsi_cmd_id_in == 4'(g - 1);
			else if (g == 9) assign hit = check_cond_evt_in;
			else if (g <= 17) assign hit = scsi_cmd_evt_in &&
				scsi_cmd_id_in == 4'(g - 2);
			else assign hit = tgt_sel_evt_in; // Target selections
			// Clear wins over an event in the same cycle
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) stat[g] <= 32'h0;
				else if (clr_done) stat[g] <= 32'h0;
				else if (hit) stat[g] <= stat[g] + 32'h1;
			end
		end
	endgenerate
	// Memory write output
	always_comb begin
		mwr_out.valid = state == bcch_pkg::BCCH_XFER;
		mwr_out.addr  = pb[2] + {25'h0, widx, 2'b00};
		mwr_out.amod  = amod[5:0];
		// Index runs past the table only while valid is low
		mwr_out.data  = (widx <= `BCCH_STAT_LAST) ? stat[widx] : 32'h0;
	end
	// Two idle cycles on the memory write port
	sequence no_xfer_s;
		!mwr_out.valid ##1 !mwr_out.valid;
	endsequence
	// Identity status carries the identifier
	ident_id_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		done_p |=> sb[0] == $past(pb[0], 2))
		else $error("identifier not copied");
	// Flags set complete after done
	flags_done_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		done_p |=> sb[1][7] && sb[1][5:0] == 6'h0)
		else $error("flags byte wrong");
	// Error code tied to error flag
	err_flag_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		done_p |=> sb[1][6] == (sb[1][15:8] != 8'h0))
		else $error("error flag mismatch");
	// Stop when not running
	stop_idle_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		state == bcch_pkg::BCCH_DEC && !list_on &&
		adapter_byte == `BCCH_ADAPTER_BOARD &&
		cmd_code == `BCCH_CMD_STOP |=> err == `BCCH_ERR_NOT_RUNNING)
		else $error("stop error code missing");
	// Halt stops acceptance until drained
	halt_drain_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		state == bcch_pkg::BCCH_DRAIN |-> !list_accept_out)
		else $error("accepting while halting");
	// Halt status held back while the queue still drains
	drain_hold_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		state == bcch_pkg::BCCH_DRAIN && !queue_empty_in |=>
		state == bcch_pkg::BCCH_DRAIN)
		else $error("halt status before drain");
	// Flags cleared when a command starts, so pollers wait
	flags_clr_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		go_wr |=> sb[1][7:0] == 8'h00)
		else $error("stale flags after go");
	// Clear performs no transfer
	clr_nox_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		clr_done |=> no_xfer_s)
		else $error("transfer on clear");
	// Clear zeroes the ID 3 and target selection counters
	clr_zero_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		clr_done |=> stat[4] == 32'h0 && stat[18] == 32'h0)
		else $error("table not cleared");
	// Option flags layout
	opt_fix_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		opt_flags[3:1] == `BCCH_OPT_FIXED &&
		opt_flags[4] == bus_reset_jumper_in &&
		opt_flags[7:5] == scsi_id_in[2:0] &&
		opt_flags[0] == scsi_id_in[3])
		else $error("option flags wrong");
	// Write uses block modifier
	amod_use_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		mwr_out.valid |-> mwr_out.amod == pb[1][13:8])
		else $error("address modifier wrong");
endmodule

//--- tb/bcch_mem_model.sv
// Memory model that takes the handler's statistics writes
module bcch_mem_model (
	// Clock and reset
	input  wire logic                clk_in,
	input  wire logic                rst_b_in,
	// Write port from the handler
	input  wire bcch_pkg::bcch_mwr_s mwr_in,
	input  wire logic [31:0]         base_in,
	input  wire logic                slow_in,
	output logic                     ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] words [0:18]; // Words stored by index
	logic [5:0]  amod;         // Last modifier seen
	int          count = 0;    // Words taken so far
	// Ready always up, or every other cycle when slow
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ready_out <= 1'b0;
		end else begin
			ready_out <= slow_in ? !ready_out : 1'b1;
		end
	end
	// Keep each taken word at its offset from the base
	always @(posedge clk_in) begin
		if (mwr_in.valid && ready_out) begin
			words[(mwr_in.addr - base_in) >> 2] <= mwr_in.data;
			amod <= mwr_in.amod;
			count <= count + 1;
		end
	end
endmodule

//--- tb/tb_bcch_top.sv
// Self-checking bench for the board-control command handler
`include "bcch_consts.svh"
module tb_bcch_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0]  FWR = 8'h21;    // Identity values, arbitrary
	localparam logic [7:0]  ENR = 8'h7e;
	localparam logic [7:0]  DY  = 8'h15;
	localparam logic [7:0]  MO  = 8'h06;
	localparam logic [7:0]  YR  = 8'h61;
	localparam logic [15:0] FWN = 16'h5a3c;
	localparam logic [31:0] BASE = 32'h0001_0000; // Statistics area
	logic clk_in = 1'b0, rst_b_in = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hready, hresp, jmp = 1'b0, qempty = 1'b1, mready;
	logic [3:0]  scsi_id = 4'h0, evt = 4'h0, cmd_id = 4'h0;
	logic        running, accept, slow = 1'b0;
	bcch_pkg::bcch_mwr_s mwr;
	int          err_count = 0, cmp_count = 0, cycles = 0;
	// Design under test with non-default identity
	bcch_top #(.FW_REL(FWR), .ENG_REV(ENR), .DAY(DY), .MONTH(MO), .YEAR(YR),
		.FW_NUM(FWN)) i_bcch_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .scsi_id_in(scsi_id), .bus_reset_jumper_in(jmp),
		.queue_empty_in(qempty), .cmd_done_evt_in(evt[0]),
		.check_cond_evt_in(evt[1]), .tgt_sel_evt_in(evt[2]),
		.scsi_cmd_evt_in(evt[3]), .scsi_cmd_id_in(cmd_id), .mwr_out(mwr),
		.mwr_ready_in(mready), .list_running_out(running),
		.list_accept_out(accept));
	// Far side memory
	bcch_mem_model i_bcch_mem_model (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.mwr_in(mwr), .base_in(BASE), .slow_in(slow), .ready_out(mready));
	// Clock of 40 ns
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	// Cut a hang short
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end
	// Counts and verdict
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One comparison
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Single AHB-Lite word transfer
	task automatic ahb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge clk_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_in); while (hready !== 1'b1);
		q = hrdata;
	endtask
	// Parameter block, reserved fields filled with junk, then go
	task automatic issue(input logic [31:0] id, w1, w2, w4);
		logic [31:0] q;
		ahb(1'b1, `BCCH_REG_W0, id, q);
		ahb(1'b1, `BCCH_REG_W1, w1, q);
		ahb(1'b1, `BCCH_REG_W2, w2, q);
		ahb(1'b1, `BCCH_REG_W3, 32'hdead_beef, q);
		ahb(1'b1, `BCCH_REG_W4, w4, q);
		ahb(1'b1, `BCCH_REG_GO, 32'h0, q);
	endtask
	// Wait for idle, then read the status block
	task automatic finish(output logic [3:0][31:0] sb);
		logic [31:0] q;
		int n;
		q = 32'h1;
		for (n = 0; n < 300 && q[0] !== 1'b0; n++)
			ahb(1'b0, `BCCH_REG_STAT, 32'h0, q);
		chk("busy", 32'h0, {31'h0, q[0]});
		for (n = 0; n < 4; n++)
			ahb(1'b0, `BCCH_REG_SB0 + 12'(4 * n), 32'h0, sb[n]);
	endtask
	// One statistics event pulse
	task automatic pulse(input int k, input logic [3:0] id);
		cmd_id <= id;
		evt <= 4'h1 << k;
		@(posedge clk_in);
		evt <= 4'h0;
		@(posedge clk_in);
	endtask
	// Identity for two ID and jumper settings
	task automatic t_ident();
		logic [3:0][31:0] sb;
		logic [3:0] id;
		for (int k = 0; k < 2; k++) begin
			id = k ? 4'h6 : 4'h9;
			scsi_id <= id;
			jmp <= !k;
			issue(32'h1234_0000 + k, 32'hc3c3_ffff, 32'h0, 32'h055a_5a5a);
			finish(sb);
			chk("sb0", 32'h1234_0000 + k, sb[0]);
			chk("sb1", {FWR, ENR, 16'h0080}, sb[1]);
			chk("sb2", {DY, MO, YR, id[2:0], !k, 3'b010, id[3]}, sb[2]);
			chk("sb3", {FWN, 16'h0}, sb[3]);
		end
	endtask
	// Errors: halt when stopped, wrong adapter byte, unmapped place
	task automatic t_errors();
		logic [3:0][31:0] sb;
		logic [31:0] q;
		issue(32'h0bad_0001, 32'h0000_00ff, 32'h0, 32'h0200_0000);
		finish(sb);
		chk("halt err", 32'h11c0, sb[1][15:0]);
		issue(32'h0bad_0002, 32'h0000_00a0, 32'h0, 32'h0500_0000);
		finish(sb);
		chk("adapter err", 32'h01c0, sb[1][15:0]);
		issue(32'h0bad_0003, 32'h0000_00ff, 32'h0, 32'h0700_0000);
		finish(sb);
		chk("unknown err", 32'h01c0, sb[1][15:0]);
		ahb(1'b1, 12'h040, 32'hffff_ffff, q);
		ahb(1'b0, 12'h040, 32'h0, q);
		chk("unmapped", 32'h0, q);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	// Halt drains the queue before its status
	task automatic t_halt();
		logic [3:0][31:0] sb;
		logic [31:0] q;
		ahb(1'b1, `BCCH_REG_CTRL, 32'h1, q);
		ahb(1'b0, `BCCH_REG_STAT, 32'h0, q);
		chk("list on", 32'h4, q & 32'h4);
		chk("accept on", 32'h1, {31'h0, accept});
		issue(32'h1d1d_0008, 32'h0000_00ff, 32'h0, 32'h0500_0000);
		finish(sb);
		chk("ident list", 32'h0080, sb[1][15:0]);
		qempty <= 1'b0;
		issue(32'h0a11_0003, 32'h0000_00ff, 32'h0, 32'h0200_0000);
		repeat (10) @(posedge clk_in);
		#1 chk("accept", 32'h0, {31'h0, accept});
		ahb(1'b0, `BCCH_REG_STAT, 32'h0, q);
		chk("draining", 32'h1, q & 32'h1);
		qempty <= 1'b1;
		finish(sb);
		chk("halt ok", 32'h0080, sb[1][15:0]);
		chk("list off", 32'h0, {31'h0, running});
	endtask
	// Statistics read with slow memory, clear, reread, then reset
	task automatic t_stats();
		logic [3:0][31:0] sb;
		int c0;
		pulse(3, 4'h3);
		pulse(3, 4'h3);
		pulse(3, 4'h9);
		pulse(1, 4'h0);
		pulse(2, 4'h0);
		slow <= 1'b1;
		c0 = i_bcch_mem_model.count;
		issue(32'h57a7_0004, 32'hbeef_3dff, BASE, 32'h0600_0000);
		finish(sb);
		chk("words", 32'd19, i_bcch_mem_model.count - c0);
		chk("id3", 32'h2, i_bcch_mem_model.words[4]);
		chk("id9", 32'h1, i_bcch_mem_model.words[11]);
		chk("check", 32'h1, i_bcch_mem_model.words[9]);
		chk("target", 32'h1, i_bcch_mem_model.words[18]);
		chk("amod", 32'h3d, {26'h0, i_bcch_mem_model.amod});
		c0 = i_bcch_mem_model.count;
		issue(32'h57a7_0005, 32'hbeef_3dff, BASE, 32'h0601_0000);
		finish(sb);
		chk("no xfer", 32'h0, i_bcch_mem_model.count - c0);
		slow <= 1'b0;
		issue(32'h57a7_0006, 32'h0000_12ff, BASE, 32'h0600_0000);
		finish(sb);
		chk("id3 clr", 32'h0, i_bcch_mem_model.words[4]);
		chk("amod2", 32'h12, {26'h0, i_bcch_mem_model.amod});
		pulse(2, 4'h0);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		@(posedge clk_in);
		issue(32'h57a7_0007, 32'h0000_12ff, BASE, 32'h0600_0000);
		finish(sb);
		chk("tgt rst", 32'h0, i_bcch_mem_model.words[18]);
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_in);
		rst_b_in <= 1'b1;
		@(posedge clk_in);
		t_ident();
		t_errors();
		t_halt();
		t_stats();
		stop_test();
	end
endmodule
